/* File: rtl/port_io_pkg.sv */
package port_io_pkg;

  localparam int NPORTS = 5;
  localparam int NCLKB = 6;
  localparam int PINS = 32;
  localparam int PORT_W [NPORTS] = '{1, 4, 8, 16, 32};

  // Pins given up to the link when it is enabled.
  localparam logic [31:0] LINK_PIN_MASK = 32'hffc0_0000;

  // Pad bits: [1:0] drive (00 2mA, 01 4mA, 10 8mA, 11 12mA), [2] slow
  // slew, [3] Schmitt, [5:4] pull (00 none, 01 down, 10 up, 11 keeper).
  localparam logic [5:0] PAD_RESET = 6'h01;

  // Address is {unit, register}.
  localparam logic [3:0] UNIT_CLKB_BASE = 4'h8;
  localparam logic [3:0] UNIT_LINK = 4'hf;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h1;
  localparam logic [3:0] REG_TIME = 4'h2;
  localparam logic [3:0] REG_TSTAMP = 4'h3;
  localparam logic [3:0] REG_COND = 4'h4;
  localparam logic [3:0] REG_CLKB_CFG = 4'h0;
  localparam logic [3:0] REG_LINK_EN = 4'h0;

  localparam logic [2:0] CLKB_REF = 3'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cmd_t;

  typedef struct packed {
    logic [5:0] pad;
    logic cond_neq;
    logic cond_en;
    logic rdy_out_en;
    logic rdy_in_en;
    logic [2:0] clk_sel;
    logic open_drain;
    logic dir_out;
    logic en;
  } port_ctrl_t;

  localparam port_ctrl_t CTRL_RESET = '{pad: PAD_RESET, clk_sel: CLKB_REF,
    default: 1'b0};

  typedef struct packed {
    port_ctrl_t ctrl;
    logic [31:0] xfer;
    logic full;
    logic [31:0] shreg;
    logic [4:0] shcnt;
    logic [31:0] outv;
    logic [15:0] cnt;
    logic [15:0] tm;
    logic tm_en;
    logic [15:0] tstamp;
    logic [31:0] cond_val;
  } port_st_t;

  typedef struct packed {
    logic src_pin;
    logic [7:0] div;
    logic [7:0] dcnt;
  } clkb_t;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] pulldn;
    logic [31:0][5:0] pad;
  } pins_t;

  typedef struct packed {
    port_st_t [NPORTS-1:0] port;
    clkb_t [NCLKB-1:0] clkb;
    logic link_en;
    logic pin0_q;
    pins_t pins;
    logic [31:0] rdata;
    logic [NPORTS-1:0] evt;
    logic [NPORTS-1:0] rdy_out;
  } state_t;

endpackage

/* File: rtl/port_io_clock_blocks.sv */
`timescale 1ns/1ps
module port_io_clock_blocks (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Port instruction access
  input wire port_io_pkg::cmd_t i_cmd,
  output logic [31:0] o_rdata,
  // Pins
  input wire logic [31:0] i_pin_in,
  input wire logic [port_io_pkg::NPORTS-1:0] i_ready_in,
  output port_io_pkg::pins_t o_pins,
  output logic [port_io_pkg::NPORTS-1:0] o_ready_out,
  // Events to the scheduler
  output logic [port_io_pkg::NPORTS-1:0] o_event
);
  import port_io_pkg::*;

  state_t st;
  state_t next_st;

  function automatic logic [31:0] port_mask(input int p);
    port_mask = 32'hffff_ffff >> (PINS - PORT_W[p]);
  endfunction

  function automatic logic [4:0] last_beat(input int p);
    last_beat = 5'(PINS / PORT_W[p] - 1);
  endfunction

  function automatic logic port_off(input int p, input logic link);
    port_off = link && ((port_mask(p) & LINK_PIN_MASK) != 32'h0000_0000);
  endfunction

  function automatic int clk_pick(input logic [2:0] sel);
    clk_pick = (int'(sel) < NCLKB) ? int'(sel) : 0;
  endfunction

  always_comb begin
    logic [NCLKB-1:0] ctick;
    logic [NPORTS-1:0] act;
    logic srcev;
    logic tk;
    logic tm_ok;
    logic cond_ok;
    logic [31:0] smp;
    logic [31:0] nsh;
    logic [31:0] pm;
    logic [3:0] unit;
    logic [3:0] rg;
    int w;
    ctick = '0;
    act = '0;
    srcev = 1'b0;
    tk = 1'b0;
    tm_ok = 1'b0;
    cond_ok = 1'b0;
    smp = '0;
    nsh = '0;
    pm = '0;
    unit = i_cmd.addr[7:4];
    rg = i_cmd.addr[3:0];
    w = 1;
    next_st = st;
    next_st.pin0_q = i_pin_in[0];
    next_st.rdata = '0;
    next_st.evt = '0;

    // Block zero ticks on every reference edge; the others divide either
    // the reference or rising edges of the one-bit port pin.
    for (int b = 0; b < NCLKB; b++) begin
      srcev = st.clkb[b].src_pin ? (i_pin_in[0] & ~st.pin0_q) : 1'b1;
      if (b == 0) begin
        ctick[b] = 1'b1;
      end else if (srcev) begin
        if (st.clkb[b].dcnt == st.clkb[b].div) begin
          ctick[b] = 1'b1;
          next_st.clkb[b].dcnt = '0;
        end else begin
          next_st.clkb[b].dcnt = st.clkb[b].dcnt + 8'h01;
        end
      end
    end

    for (int p = 0; p < NPORTS; p++) begin
      w = PORT_W[p];
      act[p] = st.port[p].ctrl.en && !port_off(p, st.link_en);
      tk = act[p] && ctick[clk_pick(st.port[p].ctrl.clk_sel)];
      tm_ok = !st.port[p].tm_en || (st.port[p].cnt == st.port[p].tm);
      if (tk) begin
        next_st.port[p].cnt = st.port[p].cnt + 16'h0001;
        if (st.port[p].ctrl.dir_out) begin
          if (st.port[p].shcnt != 5'h00) begin
            next_st.port[p].outv = st.port[p].shreg & port_mask(p);
            next_st.port[p].shreg = st.port[p].shreg >> w;
            next_st.port[p].shcnt = st.port[p].shcnt - 5'h01;
            next_st.rdy_out[p] = st.port[p].ctrl.rdy_out_en;
          end else if (st.port[p].full && tm_ok) begin
            next_st.port[p].outv = st.port[p].xfer & port_mask(p);
            next_st.port[p].shreg = st.port[p].xfer >> w;
            next_st.port[p].shcnt = last_beat(p);
            next_st.port[p].full = 1'b0;
            next_st.port[p].tstamp = st.port[p].cnt;
            next_st.port[p].tm_en = 1'b0;
            next_st.evt[p] = 1'b1;
            next_st.rdy_out[p] = st.port[p].ctrl.rdy_out_en;
          end else begin
            next_st.rdy_out[p] = 1'b0;
          end
        end else begin
          next_st.rdy_out[p] = 1'b0;
          smp = i_pin_in & port_mask(p);
          cond_ok = !st.port[p].ctrl.cond_en ||
            ((smp == (st.port[p].cond_val & port_mask(p))) !=
             st.port[p].ctrl.cond_neq);
          if (tm_ok && cond_ok &&
              (!st.port[p].ctrl.rdy_in_en || i_ready_in[p])) begin
            nsh = (st.port[p].shreg >> w) | (smp << (PINS - w));
            next_st.port[p].shreg = nsh;
            next_st.port[p].tm_en = 1'b0;
            if (st.port[p].shcnt == last_beat(p)) begin
              next_st.port[p].xfer = nsh;
              next_st.port[p].full = 1'b1;
              next_st.port[p].shcnt = '0;
              next_st.port[p].tstamp = st.port[p].cnt;
              next_st.evt[p] = 1'b1;
            end else begin
              next_st.port[p].shcnt = st.port[p].shcnt + 5'h01;
            end
          end
        end
      end else if (!act[p]) begin
        next_st.rdy_out[p] = 1'b0;
      end

      // Port instructions finish in the cycle they are issued.
      if (unit == 4'(p)) begin
        if (rg == REG_CTRL) begin
          if (i_cmd.wr) begin
            next_st.port[p].ctrl = port_ctrl_t'(i_cmd.wdata[15:0]);
            // A new setup drops any half-shifted word.
            next_st.port[p].shcnt = '0;
          end
          next_st.rdata = {13'h0000, st.port[p].tm_en,
            st.port[p].shcnt != 5'h00, st.port[p].full, st.port[p].ctrl};
        end else if (rg == REG_DATA) begin
          if (i_cmd.wr && st.port[p].ctrl.dir_out && !st.port[p].full) begin
            next_st.port[p].xfer = i_cmd.wdata;
            next_st.port[p].full = 1'b1;
          end
          if (i_cmd.rd && !st.port[p].ctrl.dir_out && !next_st.evt[p]) begin
            // A word landing in this same cycle stays pending.
            next_st.port[p].full = 1'b0;
          end
          next_st.rdata = st.port[p].xfer;
        end else if (rg == REG_TIME) begin
          if (i_cmd.wr) begin
            next_st.port[p].tm = i_cmd.wdata[15:0];
            next_st.port[p].tm_en = 1'b1;
          end
          next_st.rdata = {16'h0000, st.port[p].cnt};
        end else if (rg == REG_TSTAMP) begin
          next_st.rdata = {16'h0000, st.port[p].tstamp};
        end else if (rg == REG_COND) begin
          if (i_cmd.wr) begin
            next_st.port[p].cond_val = i_cmd.wdata;
          end
          next_st.rdata = st.port[p].cond_val;
        end
      end
    end

    for (int b = 1; b < NCLKB; b++) begin
      if (unit == UNIT_CLKB_BASE + 4'(b) && rg == REG_CLKB_CFG) begin
        if (i_cmd.wr) begin
          next_st.clkb[b].src_pin = i_cmd.wdata[8];
          next_st.clkb[b].div = i_cmd.wdata[7:0];
          next_st.clkb[b].dcnt = '0;
        end
        next_st.rdata = {23'h000000, st.clkb[b].src_pin, st.clkb[b].div};
      end
    end
    if (unit == UNIT_LINK && rg == REG_LINK_EN) begin
      if (i_cmd.wr) begin
        next_st.link_en = i_cmd.wdata[0];
      end
      next_st.rdata = {31'h00000000, st.link_en};
    end
    if (!i_cmd.rd) begin
      next_st.rdata = '0;
    end

    // Pin ownership: walk from widest to narrowest so the narrowest
    // enabled port wins each shared pin.
    for (int j = 0; j < PINS; j++) begin
      next_st.pins.out[j] = 1'b0;
      next_st.pins.oe[j] = 1'b0;
      next_st.pins.pulldn[j] = !(st.link_en && LINK_PIN_MASK[j]);
      next_st.pins.pad[j] = PAD_RESET;
      for (int p = NPORTS - 1; p >= 0; p--) begin
        pm = port_mask(p);
        if (act[p] && pm[j]) begin
          next_st.pins.pulldn[j] = 1'b0;
          next_st.pins.pad[j] = st.port[p].ctrl.pad;
          if (st.port[p].ctrl.dir_out) begin
            if (st.port[p].ctrl.open_drain) begin
              next_st.pins.out[j] = 1'b0;
              next_st.pins.oe[j] = ~st.port[p].outv[j];
            end else begin
              next_st.pins.out[j] = st.port[p].outv[j];
              next_st.pins.oe[j] = 1'b1;
            end
          end else begin
            next_st.pins.out[j] = 1'b0;
            next_st.pins.oe[j] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int p = 0; p < NPORTS; p++) begin
        st.port[p] <= '0;
        st.port[p].ctrl <= CTRL_RESET;
      end
      st.clkb <= '0;
      st.link_en <= 1'b0;
      st.pin0_q <= 1'b0;
      st.pins.out <= '0;
      st.pins.oe <= '0;
      st.pins.pulldn <= 32'hffff_ffff;
      st.pins.pad <= {PINS{PAD_RESET}};
      st.rdata <= '0;
      st.evt <= '0;
      st.rdy_out <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_pins = st.pins;
  assign o_ready_out = st.rdy_out;
  assign o_event = st.evt;

endmodule

/* File: verif/port_io_assertions.sv */
`timescale 1ns/1ps
module port_io_assertions
  import port_io_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Watched ports
  input wire cmd_t i_cmd,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] i_pin_in,
  input wire logic [NPORTS-1:0] i_ready_in,
  input wire pins_t o_pins,
  input wire logic [NPORTS-1:0] o_ready_out,
  input wire logic [NPORTS-1:0] o_event
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic [4:0] ro_en;
  logic ctl_wr;
  assign ctl_wr = i_cmd.wr && i_cmd.addr < 8'h50 && i_cmd.addr[3:0] == 4'h0;
  // Tracks which ports were allowed to raise ready-out.
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn) ro_en <= '0;
    else if (ctl_wr) ro_en[i_cmd.addr[6:4]] <= i_cmd.wdata[7];

  rdata_idle_a: assert property (!$past(i_cmd.rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  ctrl_readback_a: assert property ((ctl_wr ##1 i_cmd.rd &&
    i_cmd.addr == $past(i_cmd.addr)) |=>
    o_rdata[15:0] == $past(i_cmd.wdata[15:0], 2))
    else $error("control readback differs");
  unmapped_rd_a: assert property (i_cmd.rd && i_cmd.addr == 8'h50 |=>
    o_rdata == 32'h0) else $error("unmapped read not zero");
  reset_pins_a: assert property ($rose(i_resetn) |->
    o_pins.oe == 32'h0 && &o_pins.pulldn) else $error("pins not idle");
  reset_quiet_a: assert property ($rose(i_resetn) |->
    o_event == '0 && o_ready_out == '0) else $error("strobes after reset");
  link_off_a: assert property (i_cmd.wr && i_cmd.addr == 8'hf0 &&
    i_cmd.wdata[0] |-> ##2 o_pins.oe[31:22] == 10'h0)
    else $error("link pins still driven");
  link_pull_a: assert property (i_cmd.wr && i_cmd.addr == 8'hf0 &&
    i_cmd.wdata[0] |-> ##2 o_pins.pulldn[31:22] == 10'h0)
    else $error("link pins still pulled down");
  ready_gate_a: assert property ((o_ready_out & ~ro_en & ~$past(ro_en) &
    ~$past(ro_en, 2)) == '0) else $error("ready-out not enabled");
  counter_step_a: assert property ((i_cmd.rd && i_cmd.addr == 8'h02) [*2]
    |=> o_rdata[15:0] == $past(o_rdata[15:0]) + 16'h1)
    else $error("counter did not step by one");

  cover property (o_event[1]);
  cover property (o_ready_out[4]);
  cover property (o_pins.oe[7:0] == 8'h5a);
endmodule

bind port_io_clock_blocks port_io_assertions u_chk (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_cmd(i_cmd), .o_rdata(o_rdata),
  .i_pin_in(i_pin_in), .i_ready_in(i_ready_in), .o_pins(o_pins),
  .o_ready_out(o_ready_out), .o_event(o_event));

/* File: verif/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner
  import port_io_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Device pins and the far side's own drive
  input wire pins_t i_pins,
  input wire logic [31:0] i_ext,
  input wire logic [31:0] i_ext_en,
  input wire logic [NPORTS-1:0] i_rdy,
  input wire logic i_slow,
  // Wire levels seen by the device
  output logic [31:0] o_level,
  output logic [NPORTS-1:0] o_ready_in
);
  logic [31:0] noise = 32'h1;
  always_ff @(posedge i_clk) noise <= {noise[30:0], ~noise[31]};
  // A pin nobody drives and nothing pulls wanders, so stale values never pass.
  always_comb
    for (int b = 0; b < 32; b++)
      o_level[b] = i_pins.oe[b] ? i_pins.out[b] : i_ext_en[b] ? i_ext[b] :
        i_pins.pulldn[b] ? 1'b0 : noise[b];
  assign o_ready_in = i_rdy & {NPORTS{~i_slow | noise[0]}};
endmodule

/* File: verif/tb_port_io_clock_blocks.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_port_io_clock_blocks;
  import port_io_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  cmd_t i_cmd = '0;
  logic [31:0] lvl;
  logic [31:0] ext = '0;
  logic [31:0] rdata;
  logic [31:0] rd_v;
  logic [31:0] w;
  logic [31:0] ts;
  logic [31:0] seed = 32'he8b25db2;
  logic [4:0] rdy = '0;
  logic [4:0] rdy_in;
  logic [4:0] ro;
  logic [4:0] ev;
  logic slow = 1'b0;
  logic seen;
  pins_t pins;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  port_io_clock_blocks uut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cmd(i_cmd), .o_rdata(rdata), .i_pin_in(lvl), .i_ready_in(rdy_in),
    .o_pins(pins), .o_ready_out(ro), .o_event(ev));
  pin_partner u_ext (.i_clk(i_sys_clk), .i_pins(pins), .i_ext(ext),
    .i_ext_en(32'hf), .i_rdy(rdy), .i_slow(slow), .o_level(lvl),
    .o_ready_in(rdy_in));

  initial forever #20 i_sys_clk = ~i_sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task bus(input logic wr, input logic rd, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge i_sys_clk);
    i_cmd <= '{addr: a, wdata: d, wr: wr, rd: rd};
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, 8'h0, 32'h0);
  endtask
  task rdr(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, 8'h0, 32'h0);
    #1 rd_v = rdata;
  endtask
  // Watches port 1 events for n cycles.
  task ev_wait(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge i_sys_clk);
      #1 seen = seen | ev[1];
    end
  endtask

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    #1 `CHK(pins.pad[5], 6'h01)
    for (int p = 0; p < 5; p++) begin
      rdr({p[3:0], 4'h0});
      `CHK(rd_v, 32'h400)
    end
    $display("reset test done");
    repeat (8) begin
      seed = lfsr(seed);
      w = seed & 32'hffde;
      bus(1'b1, 1'b0, 8'h30, w);
      rdr(8'h30);
      `CHK(rd_v[15:0], w[15:0])
    end
    wrr(8'h30, 32'h0);
    rdr(8'h50);
    `CHK(rd_v, 32'h0)
    wrr(8'h00, 32'h1);
    bus(1'b0, 1'b1, 8'h02, 32'h0);
    rdr(8'h02);
    ts = rd_v;
    rdr(8'h02);
    `CHK(16'(rd_v[15:0] - ts[15:0]), 16'h0002)
    wrr(8'h00, 32'h0);
    // Block 1 divides the reference by four; port 3 runs from it.
    wrr(8'h90, 32'h3);
    wrr(8'h30, 32'h9);
    rdr(8'h32);
    ts = rd_v;
    repeat (38) @(posedge i_sys_clk);
    rdr(8'h32);
    `CHK(16'(rd_v[15:0] - ts[15:0]), 16'h000a)
    // Block 1 then ticks on every second rising edge of pin 0.
    wrr(8'h90, 32'h101);
    rdr(8'h32);
    ts = rd_v;
    repeat (16) begin
      @(posedge i_sys_clk);
      ext <= ext ^ 32'h1;
    end
    rdr(8'h32);
    `CHK(16'(rd_v[15:0] - ts[15:0]), 16'h0004)
    wrr(8'h30, 32'h0);
    $display("register test done");
    seed = lfsr(seed);
    w = seed | 32'h1;
    wrr(8'h40, 32'h83);
    wrr(8'h41, w);
    for (int k = 0; k < 8 && ro[4] !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    `CHK(ro[4], 1'b1)
    repeat (2) @(posedge i_sys_clk);
    #1 `CHK(pins.oe, 32'hffffffff)
    `CHK(lvl, w)
    wrr(8'h00, 32'h3);
    wrr(8'h01, 32'h0);
    repeat (4) @(posedge i_sys_clk);
    #1 `CHK(pins.out, w & 32'hfffffffe)
    wrr(8'h00, 32'h0);
    wrr(8'h20, 32'h7);
    wrr(8'h21, 32'ha5);
    #1;
    for (int k = 0; k < 8 && pins.oe[7:0] !== 8'h5a; k++) #40;
    `CHK(pins.oe[7:0], 8'h5a)
    `CHK(pins.out[7:0], 8'h00)
    wrr(8'hf0, 32'h1);
    repeat (2) @(posedge i_sys_clk);
    #1 `CHK(pins.oe[31:22], 10'h0)
    wrr(8'hf0, 32'h0);
    rdr(8'h42);
    ts = rd_v + 32'h20;
    wrr(8'h42, ts);
    wrr(8'h41, 32'h0);
    repeat (40) @(posedge i_sys_clk);
    rdr(8'h43);
    `CHK(rd_v[15:0], ts[15:0])
    wrr(8'h20, 32'h0);
    wrr(8'h40, 32'h0);
    $display("output test done");
    ext <= 32'h9;
    wrr(8'h14, 32'h5);
    wrr(8'h10, 32'h101);
    ev_wait(40);
    `CHK(seen, 1'b0)
    ext <= 32'h5;
    ev_wait(40);
    `CHK(seen, 1'b1)
    rdr(8'h11);
    `CHK(rd_v, 32'h55555555)
    rdr(8'h13);
    ts = rd_v;
    rdr(8'h12);
    `CHK(16'(rd_v[15:0] - ts[15:0]) < 16'd48, 1'b1)
    wrr(8'h10, 32'h41);
    ev_wait(40);
    `CHK(seen, 1'b0)
    rdy <= 5'h02;
    slow <= 1'b1;
    ev_wait(200);
    `CHK(seen, 1'b1)
    $display("input test done");
    finish_test();
  end
endmodule
